//--- inc/event_flag_pkg.sv
`default_nettype none
package event_flag_pkg;
    // ------------------------------------------------------------
    // control bus geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned LEM_W  = 8;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_EVENT_FLAGS     = 5'h02;
    localparam logic [4:0] OFS_EVENT_MASK      = 5'h03;
    localparam logic [4:0] OFS_TX_STATE        = 5'h04;
    localparam logic [4:0] OFS_RX_COND_A       = 5'h09;
    localparam logic [4:0] OFS_RX_COND_B       = 5'h0a;
    localparam logic [4:0] OFS_EVENT_CMP       = 5'h1a;
    localparam logic [4:0] OFS_TX_STATE_CMP    = 5'h1b;
    localparam logic [4:0] OFS_RX_COND_A_CMP   = 5'h1c;
    localparam logic [4:0] OFS_RX_COND_B_CMP   = 5'h1d;

    // read-only registers of the device; a write to any of them is rejected
    localparam logic [4:0] OFS_RO_RX_STATE     = 5'h08;
    localparam logic [4:0] OFS_RO_NOISE_CNT    = 5'h0f;
    localparam logic [4:0] OFS_RO_NOISE_PRE    = 5'h10;
    localparam logic [4:0] OFS_RO_STATE_CNT    = 5'h13;
    localparam logic [4:0] OFS_RO_STATE_PRE    = 5'h14;
    localparam logic [4:0] OFS_RO_LINK_ERR     = 5'h16;
    localparam logic [4:0] OFS_RO_DEVICE_ID    = 5'h18;
    localparam logic [4:0] OFS_RO_INJECT_CNT   = 5'h19;
    localparam logic [4:0] OFS_RO_RESERVED_0   = 5'h1e;
    localparam logic [4:0] OFS_RESERVED_REG_ONE = 5'h1f;

    // ------------------------------------------------------------
    // event flag bit positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_REQ_PARITY     = 0;
    localparam int unsigned BIT_BUS_PARITY     = 1;
    localparam int unsigned BIT_WRITE_REJECT   = 2;
    localparam int unsigned BIT_WRITE_CONFLICT = 3;
    localparam int unsigned BIT_LINK_ERR_THR   = 4;
    localparam int unsigned BIT_RX_SUMMARY_A   = 5;
    localparam int unsigned BIT_RX_SUMMARY_B   = 6;
    localparam int unsigned BIT_USER_SENSE     = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_EVENT_FLAGS = 8'h10;
    localparam logic [7:0] RST_EVENT_MASK  = 8'h00;
    localparam logic [7:0] RST_TX_STATE    = 8'ha2;
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [7:0] LEM_ONE         = 8'h01;
endpackage : event_flag_pkg
`default_nettype wire

//--- hw/event_flag_conditional_write.sv
// How it works
// R1 - conflicting protected write sets conflict flag
// R2 - mismatched bits keep value on protected write
// R3 - four compare registers pair with protected ones
// R4 - host alone clears conflict flag
// R5 - link error counter reaching zero sets flag
// R6 - link error threshold flag is sticky
// R7 - reset zeroes counter, sets threshold flag
// R8 - masked receive condition A sets summary A
// R9 - summary A clears after condition A gone
// R10 - masked receive condition B sets summary B
// R11 - summary B clears after condition B gone
// R12 - any sense bit sets user sense flag
// R13 - user sense clears only with both zero
// R14 - masked pending flag drives interrupt low
// R15 - event flags always readable, writes conditional
// R16 - write to read-only register sets reject
// R17 - reset clears the event mask
// R18 - host copies flags to compare before clearing
`default_nettype none
module event_flag_conditional_write (
    input  wire logic       core_clk_i,         // core clock, 200 MHz
    input  wire logic       rst_b_i,            // async reset, active low
    input  wire logic       cb_wr_i,            // control bus write strobe
    input  wire logic       cb_rd_i,            // control bus read strobe
    input  wire logic [4:0] cb_addr_i,          // control bus register address
    input  wire logic [7:0] cb_wdata_i,         // control bus write data
    output logic      [7:0] cb_rdata_o,         // read data, one cycle after read
    input  wire logic       req_parity_err_i,   // request data parity error pulse
    input  wire logic       bus_parity_err_i,   // control bus parity error pulse
    input  wire logic       lem_load_i,         // load link error counter
    input  wire logic [7:0] lem_load_value_i,   // value for counter load
    input  wire logic       lem_error_i,        // one link error seen
    input  wire logic [7:0] rx_cond_a_set_i,    // receive condition A events
    input  wire logic [7:0] rx_cond_b_set_i,    // receive condition B events
    input  wire logic [7:0] rx_mask_reg_a_i,    // receive mask A
    input  wire logic [7:0] rx_mask_reg_b_i,    // receive mask B
    input  wire logic [1:0] user_sense_i,       // sense pins, asynchronous
    output logic      [7:0] tx_state_o,         // transmit state register
    output logic            int_b_o             // interrupt, active low
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // bits that differ from the compare copy hold; the rest take the write
    function automatic logic [7:0] cond_merge(input logic [7:0] cur,
                                              input logic [7:0] cmp,
                                              input logic [7:0] wd);
        logic [7:0] hold;
        hold = cur ^ cmp;
        return (cur & hold) | (wd & ~hold);
    endfunction : cond_merge

    function automatic logic is_read_only(input logic [4:0] a);
        return (a == event_flag_pkg::OFS_RO_RX_STATE) || (a == event_flag_pkg::OFS_RO_NOISE_CNT) ||
               (a == event_flag_pkg::OFS_RO_NOISE_PRE) || (a == event_flag_pkg::OFS_RO_STATE_CNT) ||
               (a == event_flag_pkg::OFS_RO_STATE_PRE) || (a == event_flag_pkg::OFS_RO_LINK_ERR) ||
               (a == event_flag_pkg::OFS_RO_DEVICE_ID) || (a == event_flag_pkg::OFS_RO_INJECT_CNT) ||
               (a == event_flag_pkg::OFS_RO_RESERVED_0) || (a == event_flag_pkg::OFS_RESERVED_REG_ONE);
    endfunction : is_read_only

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] event_flags_ff,     nxt_event_flags;
    logic [7:0] event_mask_ff,      nxt_event_mask;
    logic [7:0] tx_state_ff,        nxt_tx_state;
    logic [7:0] rx_cond_a_ff,       nxt_rx_cond_a;
    logic [7:0] rx_cond_b_ff,       nxt_rx_cond_b;
    logic [7:0] event_cmp_ff,       nxt_event_cmp;
    logic [7:0] tx_cmp_ff,          nxt_tx_cmp;
    logic [7:0] rx_a_cmp_ff,        nxt_rx_a_cmp;
    logic [7:0] rx_b_cmp_ff,        nxt_rx_b_cmp;
    logic [7:0] lem_cnt_ff,         nxt_lem_cnt;
    logic [7:0] rdata_ff,           nxt_rdata;
    logic       int_b_ff,           nxt_int_b;
    logic [1:0] sense_meta_ff;
    logic [1:0] sense_sync_ff;

    logic       wr_flags, wr_tx, wr_rx_a, wr_rx_b;
    logic       conflict;
    logic       lem_hit;
    logic [7:0] hw_set;

    // ------------------------------------------------------------
    // sense pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sense_meta_ff <= 2'h0;
            sense_sync_ff <= 2'h0;
        end
        else
        begin
            sense_meta_ff <= user_sense_i;
            sense_sync_ff <= sense_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        wr_flags = cb_wr_i && (cb_addr_i == event_flag_pkg::OFS_EVENT_FLAGS);
        wr_tx    = cb_wr_i && (cb_addr_i == event_flag_pkg::OFS_TX_STATE);
        wr_rx_a  = cb_wr_i && (cb_addr_i == event_flag_pkg::OFS_RX_COND_A);
        wr_rx_b  = cb_wr_i && (cb_addr_i == event_flag_pkg::OFS_RX_COND_B);

        // any differing bit in the addressed pair is a conflict
        conflict = (wr_flags && ((event_flags_ff ^ event_cmp_ff) != 8'h00)) ||
                   (wr_tx    && ((tx_state_ff ^ tx_cmp_ff) != 8'h00)) ||
                   (wr_rx_a  && ((rx_cond_a_ff ^ rx_a_cmp_ff) != 8'h00)) ||
                   (wr_rx_b  && ((rx_cond_b_ff ^ rx_b_cmp_ff) != 8'h00)); // R1

        // counter parks at zero; only a step from one to zero fires
        lem_hit     = lem_error_i && !lem_load_i && (lem_cnt_ff == event_flag_pkg::LEM_ONE); // R5
        nxt_lem_cnt = lem_cnt_ff;
        if (lem_load_i)
            nxt_lem_cnt = lem_load_value_i;
        else if (lem_error_i && (lem_cnt_ff != event_flag_pkg::RST_ZERO))
            nxt_lem_cnt = lem_cnt_ff - event_flag_pkg::LEM_ONE;

        nxt_rx_cond_a = (wr_rx_a ? cond_merge(rx_cond_a_ff, rx_a_cmp_ff, cb_wdata_i) : rx_cond_a_ff)
                        | rx_cond_a_set_i; // R2
        nxt_rx_cond_b = (wr_rx_b ? cond_merge(rx_cond_b_ff, rx_b_cmp_ff, cb_wdata_i) : rx_cond_b_ff)
                        | rx_cond_b_set_i; // R2
        nxt_tx_state  = wr_tx ? cond_merge(tx_state_ff, tx_cmp_ff, cb_wdata_i) : tx_state_ff; // R2

        // hardware sets win over a clearing write in the same cycle
        hw_set = 8'h00;
        hw_set[event_flag_pkg::BIT_REQ_PARITY]     = req_parity_err_i;
        hw_set[event_flag_pkg::BIT_BUS_PARITY]     = bus_parity_err_i;
        hw_set[event_flag_pkg::BIT_WRITE_REJECT]   = cb_wr_i && is_read_only(cb_addr_i); // R16
        hw_set[event_flag_pkg::BIT_WRITE_CONFLICT] = conflict; // R1
        hw_set[event_flag_pkg::BIT_LINK_ERR_THR]   = lem_hit; // R5
        // level sources keep the summary bits up until the cause is gone
        hw_set[event_flag_pkg::BIT_RX_SUMMARY_A]   = |(rx_cond_a_ff & rx_mask_reg_a_i); // R8 R9
        hw_set[event_flag_pkg::BIT_RX_SUMMARY_B]   = |(rx_cond_b_ff & rx_mask_reg_b_i); // R10 R11
        hw_set[event_flag_pkg::BIT_USER_SENSE]     = |sense_sync_ff; // R12 R13

        // no path clears a flag except a host write
        nxt_event_flags = (wr_flags ? cond_merge(event_flags_ff, event_cmp_ff, cb_wdata_i) : event_flags_ff)
                          | hw_set; // R2 R4 R6 R15

        nxt_event_mask = (cb_wr_i && (cb_addr_i == event_flag_pkg::OFS_EVENT_MASK)) ? cb_wdata_i : event_mask_ff;
        nxt_event_cmp  = (cb_wr_i && (cb_addr_i == event_flag_pkg::OFS_EVENT_CMP)) ? cb_wdata_i : event_cmp_ff; // R3
        nxt_tx_cmp     = (cb_wr_i && (cb_addr_i == event_flag_pkg::OFS_TX_STATE_CMP)) ? cb_wdata_i : tx_cmp_ff; // R3
        nxt_rx_a_cmp   = (cb_wr_i && (cb_addr_i == event_flag_pkg::OFS_RX_COND_A_CMP)) ? cb_wdata_i : rx_a_cmp_ff;
        nxt_rx_b_cmp   = (cb_wr_i && (cb_addr_i == event_flag_pkg::OFS_RX_COND_B_CMP)) ? cb_wdata_i : rx_b_cmp_ff;

        nxt_int_b = ~|(event_flags_ff & event_mask_ff); // R14

        nxt_rdata = rdata_ff;
        if (cb_rd_i)
        begin
            unique case (cb_addr_i)
                event_flag_pkg::OFS_EVENT_FLAGS:   nxt_rdata = event_flags_ff; // R15
                event_flag_pkg::OFS_EVENT_MASK:    nxt_rdata = event_mask_ff;
                event_flag_pkg::OFS_TX_STATE:      nxt_rdata = tx_state_ff;
                event_flag_pkg::OFS_RX_COND_A:     nxt_rdata = rx_cond_a_ff;
                event_flag_pkg::OFS_RX_COND_B:     nxt_rdata = rx_cond_b_ff;
                event_flag_pkg::OFS_EVENT_CMP:     nxt_rdata = event_cmp_ff;
                event_flag_pkg::OFS_TX_STATE_CMP:  nxt_rdata = tx_cmp_ff;
                event_flag_pkg::OFS_RX_COND_A_CMP: nxt_rdata = rx_a_cmp_ff;
                event_flag_pkg::OFS_RX_COND_B_CMP: nxt_rdata = rx_b_cmp_ff;
                default:                           nxt_rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            event_flags_ff <= event_flag_pkg::RST_EVENT_FLAGS; // R7
            event_mask_ff  <= event_flag_pkg::RST_EVENT_MASK; // R17
            tx_state_ff    <= event_flag_pkg::RST_TX_STATE;
            rx_cond_a_ff   <= event_flag_pkg::RST_ZERO;
            rx_cond_b_ff   <= event_flag_pkg::RST_ZERO;
            event_cmp_ff   <= event_flag_pkg::RST_ZERO;
            tx_cmp_ff      <= event_flag_pkg::RST_ZERO;
            rx_a_cmp_ff    <= event_flag_pkg::RST_ZERO;
            rx_b_cmp_ff    <= event_flag_pkg::RST_ZERO;
            lem_cnt_ff     <= event_flag_pkg::RST_ZERO; // R7
            rdata_ff       <= event_flag_pkg::RST_ZERO;
            int_b_ff       <= 1'b1;
        end
        else
        begin
            event_flags_ff <= nxt_event_flags;
            event_mask_ff  <= nxt_event_mask;
            tx_state_ff    <= nxt_tx_state;
            rx_cond_a_ff   <= nxt_rx_cond_a;
            rx_cond_b_ff   <= nxt_rx_cond_b;
            event_cmp_ff   <= nxt_event_cmp;
            tx_cmp_ff      <= nxt_tx_cmp;
            rx_a_cmp_ff    <= nxt_rx_a_cmp;
            rx_b_cmp_ff    <= nxt_rx_b_cmp;
            lem_cnt_ff     <= nxt_lem_cnt;
            rdata_ff       <= nxt_rdata;
            int_b_ff       <= nxt_int_b;
        end
    end

    assign cb_rdata_o = rdata_ff;
    assign tx_state_o = tx_state_ff;
    assign int_b_o    = int_b_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_conflict_sets_flag;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (wr_tx && ((tx_state_ff ^ tx_cmp_ff) != 8'h00)) |=> event_flags_ff[3];
    endproperty
    a_conflict_sets_flag: assert property (p_conflict_sets_flag) else $error("conflict flag not set"); // R1

    property p_mismatch_holds;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        wr_tx |=> ((tx_state_ff ^ $past(tx_state_ff)) & $past(tx_state_ff ^ tx_cmp_ff)) == 8'h00;
    endproperty
    a_mismatch_holds: assert property (p_mismatch_holds) else $error("mismatched bit changed"); // R2

    property p_compare_write;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (cb_wr_i && cb_addr_i == event_flag_pkg::OFS_TX_STATE_CMP) |=> tx_cmp_ff == $past(cb_wdata_i);
    endproperty
    a_compare_write: assert property (p_compare_write) else $error("compare register not written"); // R3

    property p_conflict_sticky;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (event_flags_ff[3] && !wr_flags) |=> event_flags_ff[3];
    endproperty
    a_conflict_sticky: assert property (p_conflict_sticky) else $error("conflict flag dropped"); // R4

    property p_lem_threshold;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (lem_error_i && !lem_load_i && lem_cnt_ff == 8'h01) |=> (lem_cnt_ff == 8'h00) && event_flags_ff[4];
    endproperty
    a_lem_threshold: assert property (p_lem_threshold) else $error("threshold not flagged"); // R5

    property p_lem_sticky;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (event_flags_ff[4] && !wr_flags) |=> event_flags_ff[4];
    endproperty
    a_lem_sticky: assert property (p_lem_sticky) else $error("threshold flag dropped"); // R6

    property p_reset_values;
        @(posedge core_clk_i) $rose(rst_b_i) |-> (lem_cnt_ff == 8'h00) && event_flags_ff[4] && (event_mask_ff == 8'h00);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset state"); // R7

    property p_rx_summary_a;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (|(rx_cond_a_ff & rx_mask_reg_a_i)) |=> event_flags_ff[event_flag_pkg::BIT_RX_SUMMARY_A];
    endproperty
    a_rx_summary_a: assert property (p_rx_summary_a) else $error("receive summary A missing"); // R8

    property p_rx_summary_b;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (|(rx_cond_b_ff & rx_mask_reg_b_i)) |=> event_flags_ff[event_flag_pkg::BIT_RX_SUMMARY_B];
    endproperty
    a_rx_summary_b: assert property (p_rx_summary_b) else $error("receive summary B missing"); // R10

    // a summary may only fall once its masked cause was gone a cycle earlier
    property p_rx_clear_a;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        $fell(event_flags_ff[event_flag_pkg::BIT_RX_SUMMARY_A])
        |-> ($past(rx_cond_a_ff & rx_mask_reg_a_i) == 8'h00);
    endproperty
    a_rx_clear_a: assert property (p_rx_clear_a) else $error("summary A cleared with cause"); // R9

    property p_rx_clear_b;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        $fell(event_flags_ff[event_flag_pkg::BIT_RX_SUMMARY_B])
        |-> ($past(rx_cond_b_ff & rx_mask_reg_b_i) == 8'h00);
    endproperty
    a_rx_clear_b: assert property (p_rx_clear_b) else $error("summary B cleared with cause"); // R11

    property p_user_sense;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (|sense_sync_ff) |=> event_flags_ff[7];
    endproperty
    a_user_sense: assert property (p_user_sense) else $error("user sense flag low"); // R12

    property p_sense_clear;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        $fell(event_flags_ff[event_flag_pkg::BIT_USER_SENSE]) |-> ($past(sense_sync_ff) == 2'h0);
    endproperty
    a_sense_clear: assert property (p_sense_clear) else $error("user sense cleared with sense high"); // R13

    property p_interrupt;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (|(event_flags_ff & event_mask_ff)) |=> !int_b_o;
    endproperty
    a_interrupt: assert property (p_interrupt) else $error("interrupt not driven"); // R14

    property p_reject;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (cb_wr_i && cb_addr_i == event_flag_pkg::OFS_RESERVED_REG_ONE)
        |=> event_flags_ff[event_flag_pkg::BIT_WRITE_REJECT];
    endproperty
    a_reject: assert property (p_reject) else $error("write reject not flagged"); // R16

    c_conflict: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) wr_flags && conflict);
    c_clear_ok: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        event_flags_ff[4] && wr_flags && !conflict ##1 !event_flags_ff[4]);
    c_lem_hit: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) lem_hit);
    c_int_low: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) !int_b_o);

endmodule : event_flag_conditional_write
`default_nettype wire

//--- dv/event_flag_host_model.sv
`default_nettype none
module event_flag_host_model (
    input  wire logic       core_clk_i,  // core clock
    output logic            cb_wr_o,     // write strobe
    output logic            cb_rd_o,     // read strobe
    output logic      [4:0] cb_addr_o,   // register address
    output logic      [7:0] cb_wdata_o   // write data
);
    timeunit 1ns;
    timeprecision 100ps;

    int idle_cyc = 0;  // extra think time before each request, slows the host

    initial
    begin
        cb_wr_o    = 1'b0;
        cb_rd_o    = 1'b0;
        cb_addr_o  = 5'h00;
        cb_wdata_o = 8'h00;
    end

    // ------------------------------------------------------------
    // one bus cycle: drive after an edge, hold over the taking edge
    // ------------------------------------------------------------
    task access(input logic wr, input logic [4:0] a, input logic [7:0] d);
        repeat (idle_cyc) @(posedge core_clk_i);
        @(posedge core_clk_i);
        #1;
        cb_wr_o    = wr;
        cb_rd_o    = !wr;
        cb_addr_o  = a;
        cb_wdata_o = d;
        @(posedge core_clk_i);
        #1;
        cb_wr_o    = 1'b0;
        cb_rd_o    = 1'b0;
        // released lines carry junk, never the last value
        cb_addr_o  = ~a;
        cb_wdata_o = ~d;
    endtask : access

    // copy what was read into the compare first, so unread events survive
    task clear_flags(input logic [7:0] cur, input logic [7:0] bits);
        access(1'b1, event_flag_pkg::OFS_EVENT_CMP, cur);
        access(1'b1, event_flag_pkg::OFS_EVENT_FLAGS, cur & ~bits);
    endtask : clear_flags
endmodule : event_flag_host_model
`default_nettype wire

//--- dv/event_flag_conditional_write_tb_top.sv
`default_nettype none
module event_flag_conditional_write_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic       core_clk, rst_b, cb_wr, cb_rd, lem_load, lem_err, int_b;
    logic [4:0] cb_addr;
    logic [7:0] cb_wdata, cb_rdata, lem_val, tx_state, w, c, d;
    logic [7:0] rx_set[2], rx_mask[2];
    logic [7:0] cur[3] = '{8'ha2, 8'h00, 8'h00};
    logic [4:0] pa[3] = '{5'h04, 5'h09, 5'h0a};
    logic [4:0] ca[3] = '{5'h1b, 5'h1c, 5'h1d};
    logic [4:0] ro[10] = '{5'h08, 5'h0f, 5'h10, 5'h13, 5'h14, 5'h16, 5'h18, 5'h19, 5'h1e, 5'h1f};
    logic [1:0] sense, par;
    logic [7:0] expq[$];
    int         num_errors = 0, n_compared = 0, seed, n, j;

    event_flag_host_model u_host (.core_clk_i(core_clk), .cb_wr_o(cb_wr), .cb_rd_o(cb_rd),
        .cb_addr_o(cb_addr), .cb_wdata_o(cb_wdata));

    event_flag_conditional_write u_dut (.core_clk_i(core_clk), .rst_b_i(rst_b), .cb_wr_i(cb_wr),
        .cb_rd_i(cb_rd), .cb_addr_i(cb_addr), .cb_wdata_i(cb_wdata), .cb_rdata_o(cb_rdata),
        .req_parity_err_i(par[0]), .bus_parity_err_i(par[1]), .lem_load_i(lem_load),
        .lem_load_value_i(lem_val), .lem_error_i(lem_err), .rx_cond_a_set_i(rx_set[0]),
        .rx_cond_b_set_i(rx_set[1]), .rx_mask_reg_a_i(rx_mask[0]), .rx_mask_reg_b_i(rx_mask[1]),
        .user_sense_i(sense), .tx_state_o(tx_state), .int_b_o(int_b));

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // compare tasks, closing task
    // ------------------------------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task chk_pin(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t pin got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_pin

    task results;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    task done(input string s);
        $display("test %s ended: %0d compared, %0d mismatches", s, n_compared, num_errors);
    endtask : done

    task rd(input logic [4:0] a, input logic [7:0] exp);
        expq.push_back(exp);
        u_host.access(1'b0, a, 8'h00);
    endtask : rd

    task err_pulses(input int k);
        repeat (k)
        begin
            @(posedge core_clk);
            #1 lem_err = 1'b1;
            @(posedge core_clk);
            #1 lem_err = 1'b0;
        end
    endtask : err_pulses

    // read data lands at the taking edge; it is checked 2 ns later
    always @(posedge core_clk)
    begin
        if (cb_rd === 1'b1)
        begin
            #2;
            chk(cb_rdata, expq.pop_front());
        end
    end

    initial
    begin
        #(40000 * 5);
        num_errors++;
        results();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 68;
        {rst_b, lem_load, lem_err, lem_val, sense, par} = '0;
        rx_set = '{8'h00, 8'h00};
        rx_mask = '{8'h00, 8'h00};
        repeat (3) @(posedge core_clk);
        #1 rst_b = 1'b1;
        rd(event_flag_pkg::OFS_EVENT_FLAGS, 8'h10);
        rd(event_flag_pkg::OFS_EVENT_MASK, 8'h00);
        rd(event_flag_pkg::OFS_TX_STATE, 8'ha2);
        for (int k = 0; k < 4; k++) rd(5'(5'h1a + k), 8'h00);
        chk_pin(int_b, 1'b1);
        done("reset");
        foreach (ro[k])
        begin
            u_host.access(1'b1, ro[k], 8'($random(seed)));
            rd(5'h02, 8'h14);
            u_host.clear_flags(8'h14, 8'h04);
        end
        @(posedge core_clk);
        #1 par = 2'b11;
        @(posedge core_clk);
        #1 par = 2'b00;
        rd(5'h02, 8'h13);
        u_host.clear_flags(8'h13, 8'h03);
        rd(5'h02, 8'h10);
        done("read_only");
        u_host.access(1'b1, 5'h1a, 8'h00);
        u_host.access(1'b1, 5'h02, 8'h00);
        rd(5'h02, 8'h18);
        repeat (20) @(posedge core_clk);
        rd(5'h02, 8'h18);
        u_host.clear_flags(8'h18, 8'h18);
        rd(5'h02, 8'h00);
        done("conflict_flags");
        u_host.idle_cyc = 1;
        for (int it = 0; it < 12; it++)
        begin
            j = it % 3;
            c = 8'($random(seed));
            w = 8'($random(seed));
            u_host.access(1'b1, ca[j], c);
            u_host.access(1'b1, pa[j], w);
            d = cur[j] ^ c;
            cur[j] = (cur[j] & d) | (w & ~d);
            rd(pa[j], cur[j]);
            rd(5'h02, (d != 8'h00) ? 8'h08 : 8'h00);
            if (j == 0) chk(tx_state, cur[0]);
            if (d != 8'h00) u_host.clear_flags(8'h08, 8'h08);
        end
        u_host.idle_cyc = 0;
        done("protected_regs");
        n = ($random(seed) & 7) + 2;
        @(posedge core_clk);
        #1 {lem_load, lem_val} = {1'b1, 8'(n)};
        @(posedge core_clk);
        #1 lem_load = 1'b0;
        err_pulses(n - 1);
        rd(5'h02, 8'h00);
        err_pulses(1);
        rd(5'h02, 8'h10);
        err_pulses(2);
        @(posedge core_clk);
        #1 lem_load = 1'b1;
        @(posedge core_clk);
        #1 lem_load = 1'b0;
        rd(5'h02, 8'h10);
        u_host.clear_flags(8'h10, 8'h10);
        rd(5'h02, 8'h00);
        done("link_error");
        for (int i = 0; i < 2; i++)
        begin
            @(posedge core_clk);
            #1 rx_set[i] = 8'h01;
            @(posedge core_clk);
            #1 rx_set[i] = 8'h00;
            cur[1 + i] = cur[1 + i] | 8'h01;
            rd(5'h02, 8'h00);
            rx_mask[i] = cur[1 + i];
            rd(5'h02, 8'h20 << i);
            u_host.clear_flags(8'h20 << i, 8'h20 << i);
            rd(5'h02, 8'h20 << i);
            rx_mask[i] = 8'h00;
            u_host.clear_flags(8'h20 << i, 8'h20 << i);
            rd(5'h02, 8'h00);
            chk_pin(int_b, 1'b1);
        end
        done("rx_summary");
        u_host.access(1'b1, 5'h03, 8'h80);
        rd(5'h03, 8'h80);
        for (int s = 1; s < 4; s++)
        begin
            sense = 2'(s);
            repeat (4) @(posedge core_clk);
            rd(5'h02, 8'h80);
            chk_pin(int_b, 1'b0);
            u_host.clear_flags(8'h80, 8'h80);
            rd(5'h02, 8'h80);
            sense = 2'b00;
            repeat (4) @(posedge core_clk);
            u_host.clear_flags(8'h80, 8'h80);
            rd(5'h02, 8'h00);
            repeat (2) @(posedge core_clk);
            chk_pin(int_b, 1'b1);
        end
        done("user_sense");
        repeat (4) @(posedge core_clk);
        results();
    end
endmodule : event_flag_conditional_write_tb_top
`default_nettype wire
